// ==== pkg/pcd_pkg.sv ====
// package for the parameter channel decoder: field layout, codes, error numbers
package pcd_pkg;

  // channel word field positions
  localparam int PCD_ID_MSB = 15;
  localparam int PCD_ID_LSB = 12;
  localparam int PCD_RSV_BIT = 11;
  localparam int PCD_PNU_MSB = 10;
  localparam int PCD_SUB_MSB = 15;
  localparam int PCD_SUB_LSB = 8;
  localparam int PCD_PAGE_MSB = 7;
  localparam int PCD_CONN_MSB = 15;
  localparam int PCD_CONN_LSB = 10;
  localparam logic [5:0] PCD_CONN_MARK = 6'h3F;

  // request identifiers
  localparam logic [3:0] PCD_RQ_NONE = 4'h0;
  localparam logic [3:0] PCD_RQ_READ = 4'h1;
  localparam logic [3:0] PCD_RQ_WR16 = 4'h2;
  localparam logic [3:0] PCD_RQ_WR32 = 4'h3;
  localparam logic [3:0] PCD_RQ_DESC = 4'h4;
  localparam logic [3:0] PCD_RQ_FREAD = 4'h6;
  localparam logic [3:0] PCD_RQ_FWR16 = 4'h7;
  localparam logic [3:0] PCD_RQ_FWR32 = 4'h8;
  localparam logic [3:0] PCD_RQ_COUNT = 4'h9;

  // response identifiers
  localparam logic [3:0] PCD_RS_NONE = 4'h0;
  localparam logic [3:0] PCD_RS_WORD = 4'h1;
  localparam logic [3:0] PCD_RS_DWORD = 4'h2;
  localparam logic [3:0] PCD_RS_DESC = 4'h3;
  localparam logic [3:0] PCD_RS_FWORD = 4'h4;
  localparam logic [3:0] PCD_RS_FDWORD = 4'h5;
  localparam logic [3:0] PCD_RS_COUNT = 4'h6;
  localparam logic [3:0] PCD_RS_ERR = 4'h7;
  localparam logic [3:0] PCD_RS_NOAUTH = 4'h8;

  // error numbers
  localparam logic [7:0] PCD_E_NOPARAM = 8'h00;
  localparam logic [7:0] PCD_E_RDONLY = 8'h01;
  localparam logic [7:0] PCD_E_LIMIT = 8'h02;
  localparam logic [7:0] PCD_E_SUBIDX = 8'h03;
  localparam logic [7:0] PCD_E_NOARRAY = 8'h04;
  localparam logic [7:0] PCD_E_DTYPE = 8'h05;
  localparam logic [7:0] PCD_E_RESETONLY = 8'h06;
  localparam logic [7:0] PCD_E_DESCRO = 8'h07;
  localparam logic [7:0] PCD_E_NOMASTER = 8'h0B;
  localparam logic [7:0] PCD_E_KEYWORD = 8'h0C;
  localparam logic [7:0] PCD_E_OPSTATE = 8'h11;
  localparam logic [7:0] PCD_E_INADM = 8'h14;
  localparam logic [7:0] PCD_E_DEACT = 8'h65;
  localparam logic [7:0] PCD_E_WIDTH = 8'h66;
  localparam logic [7:0] PCD_E_ILLVAL = 8'h68;
  localparam logic [7:0] PCD_E_UNSUPP = 8'h6A;
  localparam logic [7:0] PCD_E_CLOOP = 8'h6B;
  localparam logic [7:0] PCD_E_COMMISS = 8'h86;
  localparam logic [7:0] PCD_E_PROTECT = 8'h87;
  localparam logic [7:0] PCD_E_BELOW = 8'hC8;
  localparam logic [7:0] PCD_E_ABOVE = 8'hC9;
  localparam logic [7:0] PCD_E_NOCODE = 8'hCC;

  // page index codes and offsets
  localparam logic [7:0] PCD_PG_0 = 8'h00;
  localparam logic [7:0] PCD_PG_2000 = 8'h80;
  localparam logic [7:0] PCD_PG_6000 = 8'h90;
  localparam logic [7:0] PCD_PG_8000 = 8'h20;
  localparam logic [7:0] PCD_PG_10000 = 8'hA0;
  localparam logic [7:0] PCD_PG_20000 = 8'h50;
  localparam logic [7:0] PCD_PG_30000 = 8'hF0;
  localparam logic [7:0] PCD_PG_60000 = 8'h74;
  localparam int PCD_DIRECT_LIMIT = 2000;
  localparam logic [3:0] PCD_COMMISSION_STATE = 4'hF;

  // the four-word channel
  typedef struct packed {
    logic [15:0] id_and_number_word;
    logic [15:0] index_word;
    logic [15:0] value_high_word;
    logic [15:0] value_low_word;
  } pcd_chan_t;

  // facts about the addressed parameter, supplied by the store
  typedef struct packed {
    logic exists;
    logic deactivated;
    logic writable;
    logic indexed;
    logic [7:0] elem_count;
    logic is32;
    logic is8;
    logic desc_writable;
    logic commission_only;
    logic loop_locked;
    logic reset_only;
    logic needs_keyword;
    logic needs_code;
    logic busy;
    logic [31:0] lo_abs;
    logic [31:0] hi_abs;
    logic [31:0] lo_cur;
    logic [31:0] hi_cur;
    logic discrete;
    logic value_ok;
    logic illegal_value;
  } pcd_pinfo_t;

  typedef enum logic [1:0] {
    PCD_IDLE = 2'b00,
    PCD_LOOK = 2'b01,
    PCD_ANSWER = 2'b11
  } pcd_state_t;

endpackage : pcd_pkg

// ==== core/pcd_decoder.sv ====
// parameter channel decoder: decodes a four-word request, checks it, answers once
// Behaviour
// - id bits 15..12, number 10..0, bit 11 zero
// - answer ids per request kind, 7/8 refusals
// - id 7 carries error in high word
// - request ids 6,7,8 equal 1,2,3
// - errors 00 nonexistent, 01 fixed, 02 limits
// - errors 03 bad subindex, 04 not indexed
// - error 05 wrong data type
// - error 06 nonzero write without permission
// - error 07 descriptive element is fixed; never sent, descriptive ids get 6A
// - error 0B write without master control
// - error 11 operating state, 0C keyword missing
// - error 14 inadmissible value within limits
// - error 65 parameter deactivated in mode
// - error 66 channel too narrow
// - error 6A unsupported id, 68 illegal value
// - error 86 not commissioning, 6B loop enabled
// - error 87 while protection is active
// - errors C8 below, C9 above, CC code
// - numbers below 2000 carried directly
// - higher numbers use page index offset
// - page codes map to the listed offsets
// - 8, 16 and 32 bit value placement
// - connector: number, 3F mark, index bits; only package constants, not decoded
`timescale 1ns/1ps
module pcd_decoder
  import pcd_pkg::*;
#(
  parameter int PNUM_W = 16,
  parameter bit WIDE_CHANNEL = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire pcd_chan_t req_chan,
  output pcd_chan_t rsp_chan,
  output logic rsp_valid,
  output logic [PNUM_W-1:0] lookup_num,
  output logic [7:0] lookup_sub,
  output logic lookup_valid,
  input wire pcd_pinfo_t pinfo,
  input wire logic [31:0] read_value,
  output logic wr_en,
  output logic [31:0] wr_value,
  input wire logic master_control,
  input wire logic write_authorised,
  input wire logic protect_active,
  input wire logic [3:0] commissioning_state_param
);

  initial begin
    if (PNUM_W < 16) $error("PNUM_W must hold parameter numbers up to 61999");
  end

  typedef struct packed {
    pcd_state_t st;
    pcd_chan_t req;
    logic [3:0] kind;
    logic page_ok;
    pcd_chan_t rsp;
    logic rsp_valid;
    logic [PNUM_W-1:0] num;
    logic lk;
    logic wr_en;
    logic [31:0] wr_value;
  } pcd_regs_t;

  pcd_regs_t s_reg, s_next;

  // page code to offset
  // unknown codes leave the flag bit clear
  function automatic logic [PNUM_W:0] page_offset(input logic [7:0] pg);
    logic [PNUM_W:0] r;
    r = '0;
    unique case (pg)
      PCD_PG_0: r = {1'b1, PNUM_W'(0)};
      PCD_PG_2000: r = {1'b1, PNUM_W'(2000)};
      PCD_PG_6000: r = {1'b1, PNUM_W'(6000)};
      PCD_PG_8000: r = {1'b1, PNUM_W'(8000)};
      PCD_PG_10000: r = {1'b1, PNUM_W'(10000)};
      PCD_PG_20000: r = {1'b1, PNUM_W'(20000)};
      PCD_PG_30000: r = {1'b1, PNUM_W'(30000)};
      PCD_PG_60000: r = {1'b1, PNUM_W'(60000)};
      default: r = '0;
    endcase
    return r;
  endfunction : page_offset

  function automatic logic [3:0] fold_id(input logic [3:0] id);
    logic [3:0] r;
    r = id;
    if (id == PCD_RQ_FREAD) r = PCD_RQ_READ;
    if (id == PCD_RQ_FWR16) r = PCD_RQ_WR16;
    if (id == PCD_RQ_FWR32) r = PCD_RQ_WR32;
    return r;
  endfunction : fold_id

  logic [PNUM_W:0] pg_dec;
  logic [3:0] kind_in;
  logic is_write;
  logic [31:0] wval;
  logic [7:0] err;
  logic has_err;
  logic [3:0] pos_id;
  logic field_req;

  always_comb begin
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.lk = 1'b0;
    s_next.wr_en = 1'b0;
    pg_dec = page_offset(req_chan.index_word[PCD_PAGE_MSB:0]);
    kind_in = fold_id(req_chan.id_and_number_word[PCD_ID_MSB:PCD_ID_LSB]);
    is_write = (s_reg.kind == PCD_RQ_WR16) || (s_reg.kind == PCD_RQ_WR32);
    field_req = s_reg.req.id_and_number_word[PCD_ID_MSB:PCD_ID_LSB] >= PCD_RQ_FREAD;
    // value placement: 32-bit spans both words, else low word only
    wval = (s_reg.kind == PCD_RQ_WR32) ? {s_reg.req.value_high_word, s_reg.req.value_low_word}
                                       : {16'h0000, s_reg.req.value_low_word};
    err = PCD_E_NOPARAM;
    has_err = 1'b1;
    pos_id = PCD_RS_NONE;
    ///////////////////////////////////////////////////////////////////////////
    // no descriptive write path
    if (!(s_reg.kind inside {PCD_RQ_READ, PCD_RQ_WR16, PCD_RQ_WR32, PCD_RQ_COUNT})) begin
      err = PCD_E_UNSUPP;
    end else if (!s_reg.page_ok || !pinfo.exists) begin
      err = PCD_E_NOPARAM;
    end else if (protect_active) begin
      err = PCD_E_PROTECT;
    end else if (pinfo.deactivated) begin
      err = PCD_E_DEACT;
    end else if (!pinfo.indexed && s_reg.req.index_word[PCD_SUB_MSB:PCD_SUB_LSB] != 8'h00) begin
      err = PCD_E_NOARRAY;
    end else if (pinfo.indexed && s_reg.req.index_word[PCD_SUB_MSB:PCD_SUB_LSB] >= pinfo.elem_count) begin
      err = PCD_E_SUBIDX;
    end else if (pinfo.busy) begin
      err = PCD_E_OPSTATE;
    end else if (!WIDE_CHANNEL && pinfo.is32 && !is_write && s_reg.kind != PCD_RQ_COUNT) begin
      err = PCD_E_WIDTH;
    end else if (is_write) begin
      if (!master_control) err = PCD_E_NOMASTER;
      else if (!pinfo.writable) err = PCD_E_RDONLY;
      else if (pinfo.commission_only && commissioning_state_param != PCD_COMMISSION_STATE) err = PCD_E_COMMISS;
      else if (pinfo.loop_locked) err = PCD_E_CLOOP;
      else if (pinfo.needs_code) err = PCD_E_NOCODE;
      else if (pinfo.needs_keyword) err = PCD_E_KEYWORD;
      else if (pinfo.is32 != (s_reg.kind == PCD_RQ_WR32) ||
               (pinfo.is8 && s_reg.req.value_low_word[15:8] != 8'h00)) err = PCD_E_DTYPE;
      else if (pinfo.reset_only && !write_authorised && wval != 32'h0000_0000) err = PCD_E_RESETONLY;
      else if (wval < pinfo.lo_abs || wval > pinfo.hi_abs) err = PCD_E_LIMIT;
      else if (wval < pinfo.lo_cur) err = PCD_E_BELOW;
      else if (wval > pinfo.hi_cur) err = PCD_E_ABOVE;
      else if (pinfo.illegal_value) err = PCD_E_ILLVAL;
      else if (pinfo.discrete && !pinfo.value_ok) err = PCD_E_INADM;
      else has_err = 1'b0;
    end else begin
      has_err = 1'b0;
    end
    unique case (s_reg.kind)
      PCD_RQ_WR16: pos_id = field_req ? PCD_RS_FWORD : PCD_RS_WORD;
      PCD_RQ_WR32: pos_id = field_req ? PCD_RS_FDWORD : PCD_RS_DWORD;
      PCD_RQ_COUNT: pos_id = PCD_RS_COUNT;
      default: pos_id = pinfo.is32 ? (field_req ? PCD_RS_FDWORD : PCD_RS_DWORD)
                                   : (field_req ? PCD_RS_FWORD : PCD_RS_WORD);
    endcase
    ///////////////////////////////////////////////////////////////////////////
    unique case (s_reg.st)
      PCD_IDLE: begin
        if (req_valid && kind_in != PCD_RQ_NONE) begin
          s_next.req = req_chan;
          s_next.kind = req_chan.id_and_number_word[PCD_RSV_BIT] ? 4'hF : kind_in;
          s_next.page_ok = pg_dec[PNUM_W];
          s_next.num = PNUM_W'(req_chan.id_and_number_word[PCD_PNU_MSB:0]) + pg_dec[PNUM_W-1:0];
          s_next.lk = 1'b1;
          s_next.st = PCD_LOOK;
        end
      end
      PCD_LOOK: begin
        s_next.st = PCD_ANSWER;
      end
      PCD_ANSWER: begin
        s_next.rsp.index_word = s_reg.req.index_word;
        s_next.rsp.id_and_number_word = {pos_id, 1'b0, s_reg.req.id_and_number_word[PCD_PNU_MSB:0]};
        s_next.rsp.value_high_word = 16'h0000;
        s_next.rsp.value_low_word = 16'h0000;
        if (has_err) begin
          s_next.rsp.id_and_number_word[PCD_ID_MSB:PCD_ID_LSB] =
            (err == PCD_E_NOMASTER) ? PCD_RS_NOAUTH : PCD_RS_ERR;
          s_next.rsp.value_high_word = {8'h00, err};
        end else if (s_reg.kind == PCD_RQ_COUNT) begin
          s_next.rsp.value_low_word = {8'h00, pinfo.elem_count};
        end else if (is_write) begin
          s_next.wr_en = 1'b1;
          s_next.wr_value = wval;
          s_next.rsp.value_high_word = s_reg.req.value_high_word;
          s_next.rsp.value_low_word = s_reg.req.value_low_word;
        end else begin
          s_next.rsp.value_high_word = pinfo.is32 ? read_value[31:16] : 16'h0000;
          s_next.rsp.value_low_word = pinfo.is8 ? {8'h00, read_value[7:0]} : read_value[15:0];
        end
        s_next.rsp_valid = 1'b1;
        s_next.st = PCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_reg <= '{st: PCD_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rsp_chan = s_reg.rsp;
  assign rsp_valid = s_reg.rsp_valid;
  assign lookup_num = s_reg.num;
  assign lookup_sub = s_reg.req.index_word[PCD_SUB_MSB:PCD_SUB_LSB];
  assign lookup_valid = s_reg.lk;
  assign wr_en = s_reg.wr_en;
  assign wr_value = s_reg.wr_value;

  ///////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    s_reg.st == PCD_IDLE && req_valid && kind_in != PCD_RQ_NONE;
  endsequence

  property p_one_reply;
    @(posedge clock) disable iff (!rst_n) s_take |-> ##3 rsp_valid ##1 !rsp_valid;
  endproperty
  a_one_reply: assert property (p_one_reply) else $error("request not answered exactly once");

  property p_echo;
    @(posedge clock) disable iff (!rst_n) s_take |-> ##3 rsp_chan.index_word == $past(req_chan.index_word, 3);
  endproperty
  a_echo: assert property (p_echo) else $error("index word not echoed");

  property p_bit11;
    @(posedge clock) disable iff (!rst_n) rsp_valid |-> !rsp_chan.id_and_number_word[PCD_RSV_BIT];
  endproperty
  a_bit11: assert property (p_bit11) else $error("reserved bit set in reply");

  property p_err_word;
    @(posedge clock) disable iff (!rst_n)
      rsp_valid && rsp_chan.id_and_number_word[PCD_ID_MSB:PCD_ID_LSB] == PCD_RS_ERR
      |-> rsp_chan.value_high_word[15:8] == 8'h00 && !wr_en;
  endproperty
  a_err_word: assert property (p_err_word) else $error("error reply malformed or wrote");

  property p_unsupp;
    @(posedge clock) disable iff (!rst_n)
      s_take and req_chan.id_and_number_word[PCD_ID_MSB:PCD_ID_LSB] == PCD_RQ_DESC
      |-> ##3 rsp_chan.value_high_word == {8'h00, PCD_E_UNSUPP};
  endproperty
  a_unsupp: assert property (p_unsupp) else $error("unsupported id not refused with 6A");

  property p_page;
    @(posedge clock) disable iff (!rst_n)
      s_take and !pg_dec[PNUM_W] && !req_chan.id_and_number_word[PCD_RSV_BIT] and
      fold_id(req_chan.id_and_number_word[PCD_ID_MSB:PCD_ID_LSB]) == PCD_RQ_READ
      |-> ##3 rsp_chan.value_high_word == 16'h0000 && rsp_chan.id_and_number_word[15:12] == PCD_RS_ERR;
  endproperty
  a_page: assert property (p_page) else $error("unknown page code not refused");

  property p_offset;
    @(posedge clock) disable iff (!rst_n)
      s_take and req_chan.index_word[PCD_PAGE_MSB:0] == PCD_PG_6000
      |=> lookup_valid && lookup_num == PNUM_W'($past(req_chan.id_and_number_word[PCD_PNU_MSB:0])) + PNUM_W'(6000);
  endproperty
  a_offset: assert property (p_offset) else $error("page offset not applied");

  property p_alias;
    @(posedge clock) disable iff (!rst_n)
      s_take and req_chan.id_and_number_word[15:12] == PCD_RQ_FWR16 && !req_chan.id_and_number_word[11]
      |=> s_reg.kind == PCD_RQ_WR16;
  endproperty
  a_alias: assert property (p_alias) else $error("id 7 not treated as 2");

  property p_master;
    @(posedge clock) disable iff (!rst_n)
      rsp_valid && rsp_chan.id_and_number_word[15:12] == PCD_RS_NOAUTH |-> rsp_chan.value_high_word == 16'h000B;
  endproperty
  a_master: assert property (p_master) else $error("no master reply lacks 0B");

endmodule : pcd_decoder

// ==== sim/pcd_store_model.sv ====
// parameter store model answering attribute lookups of the decoder
`timescale 1ns/1ps
module pcd_store_model
  import pcd_pkg::*;
(
  input wire logic [15:0] lookup_num,
  input wire logic [3:0] knob,
  output pcd_pinfo_t pinfo,
  output logic [31:0] read_value
);
  always_comb begin
    pinfo = '0;
    read_value = 32'hA5A5_5A5A;
    case (lookup_num)
      16'd100: begin
        pinfo.exists = 1'b1;
        pinfo.writable = 1'b1;
        pinfo.value_ok = 1'b1;
        pinfo.hi_abs = 32'd1000;
        pinfo.lo_cur = 32'd10;
        pinfo.hi_cur = 32'd900;
        read_value = 32'h0000_1234;
      end
      16'd7841: begin
        pinfo.exists = 1'b1;
        pinfo.writable = 1'b1;
        pinfo.indexed = 1'b1;
        pinfo.elem_count = 8'h04;
        pinfo.is32 = 1'b1;
        pinfo.value_ok = 1'b1;
        pinfo.hi_abs = 32'hFFFF_FFFF;
        pinfo.hi_cur = 32'hFFFF_FFFF;
        read_value = 32'h89AB_CDEF;
      end
      16'd2005: begin
        pinfo.exists = 1'b1;
        pinfo.value_ok = 1'b1;
        read_value = 32'h0000_0055;
      end
      default: ;
    endcase
    // one injected fault at a time, chosen by the bench
    case (knob)
      4'h1: pinfo.deactivated = 1'b1;
      4'h2: pinfo.busy = 1'b1;
      4'h3: pinfo.loop_locked = 1'b1;
      4'h4: pinfo.needs_code = 1'b1;
      4'h5: pinfo.needs_keyword = 1'b1;
      4'h6: pinfo.illegal_value = 1'b1;
      4'h7: begin
        pinfo.discrete = 1'b1;
        pinfo.value_ok = 1'b0;
      end
      4'h8: pinfo.commission_only = 1'b1;
      4'h9: pinfo.reset_only = 1'b1;
      default: ;
    endcase
  end
endmodule : pcd_store_model

// ==== sim/tb_top.sv ====
// testbench of the parameter channel decoder
`timescale 1ns/1ps
module tb_top;
  import pcd_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  pcd_chan_t req_chan = '0;
  pcd_chan_t rsp_chan;
  logic rsp_valid, lookup_valid, wr_en;
  logic [15:0] lookup_num;
  logic [7:0] lookup_sub;
  logic [31:0] read_value, wr_value;
  pcd_pinfo_t pinfo;
  logic master_control = 1'b1;
  logic write_authorised = 1'b0;
  logic protect_active = 1'b0;
  logic [3:0] commissioning_state_param = 4'h0;
  logic [3:0] knob = 4'h0;
  logic [15:0] seen_num;
  pcd_chan_t rsp_chan_nar;
  logic rsp_valid_nar;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  pcd_decoder #(.PNUM_W(16), .WIDE_CHANNEL(1'b1)) i_pcd_decoder (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req_chan(req_chan), .rsp_chan(rsp_chan), .rsp_valid(rsp_valid),
    .lookup_num(lookup_num), .lookup_sub(lookup_sub), .lookup_valid(lookup_valid), .pinfo(pinfo),
    .read_value(read_value), .wr_en(wr_en), .wr_value(wr_value), .master_control(master_control),
    .write_authorised(write_authorised), .protect_active(protect_active),
    .commissioning_state_param(commissioning_state_param));
  pcd_store_model i_pcd_store_model (.lookup_num(lookup_num), .knob(knob), .pinfo(pinfo),
    .read_value(read_value));
  // narrow channel twin: same requests, same store answers, refuses 32-bit reads
  pcd_decoder #(.PNUM_W(16), .WIDE_CHANNEL(1'b0)) i_pcd_decoder_nar (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req_chan(req_chan), .rsp_chan(rsp_chan_nar), .rsp_valid(rsp_valid_nar),
    .lookup_num(), .lookup_sub(), .lookup_valid(), .pinfo(pinfo),
    .read_value(read_value), .wr_en(), .wr_value(), .master_control(master_control),
    .write_authorised(write_authorised), .protect_active(protect_active),
    .commissioning_state_param(commissioning_state_param));

  initial begin
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // mode 0 error byte, 1 full value, 2 write echo and store, 3 low word only
  task automatic xfer(input logic [3:0] id, input logic [11:0] param_number_field, input logic [15:0] idx,
                      input logic [31:0] val, input logic [3:0] exp_id, input logic [31:0] exp_val, input int mode);
    int k;
    req_valid <= 1'b1;
    req_chan <= {id, param_number_field, idx, val};
    @(posedge clock);
    req_valid <= 1'b0;
    for (k = 1; k <= 6; k++) begin
      #1;
      if (lookup_valid === 1'b1) seen_num = lookup_num;
      if (rsp_valid === 1'b1) break;
      @(posedge clock);
    end
    chk("latency", 32'd3, k);
    chk("narrow_valid", 32'h1, {31'h0, rsp_valid_nar});
    chk("rsp_id", {28'h0, exp_id}, {28'h0, rsp_chan.id_and_number_word[15:12]});
    chk("index_echo", {16'h0, idx}, {16'h0, rsp_chan.index_word});
    chk("wr_en", {31'h0, mode == 2}, {31'h0, wr_en});
    if (mode == 0) chk("err_no", exp_val, {24'h0, rsp_chan.value_high_word[7:0]});
    if (mode == 1 || mode == 2) chk("value", exp_val, {rsp_chan.value_high_word, rsp_chan.value_low_word});
    if (mode == 2) chk("wr_value", val, wr_value);
    if (mode == 3) chk("count", exp_val, {16'h0, rsp_chan.value_low_word});
    @(posedge clock);
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_read();
    xfer(4'h1, 12'd100, 16'h0, 32'h0, PCD_RS_WORD, 32'h1234, 1);
    xfer(4'h6, 12'd1841, {8'h02, PCD_PG_6000}, 32'h0, PCD_RS_FDWORD, 32'h89AB_CDEF, 1);
    chk("lookup_num", 32'd7841, {16'h0, seen_num});
    chk("lookup_sub", 32'h2, {24'h0, lookup_sub});
    chk("narrow_id", {28'h0, PCD_RS_ERR}, {28'h0, rsp_chan_nar.id_and_number_word[15:12]});
    chk("narrow_err", {24'h0, PCD_E_WIDTH}, {24'h0, rsp_chan_nar.value_high_word[7:0]});
    xfer(4'h9, 12'd1841, {8'h00, PCD_PG_6000}, 32'h0, PCD_RS_COUNT, 32'h4, 3);
    xfer(4'h1, 12'd1841, {8'h09, PCD_PG_6000}, 32'h0, PCD_RS_ERR, PCD_E_SUBIDX, 0);
    xfer(4'h1, 12'd100, 16'h0100, 32'h0, PCD_RS_ERR, PCD_E_NOARRAY, 0);
    xfer(4'h1, 12'd999, 16'h0, 32'h0, PCD_RS_ERR, PCD_E_NOPARAM, 0);
    xfer(4'h4, 12'd100, 16'h0, 32'h0, PCD_RS_ERR, PCD_E_UNSUPP, 0);
    xfer(4'h5, 12'd100, 16'h0, 32'h0, PCD_RS_ERR, PCD_E_UNSUPP, 0);
    xfer(4'h1, 12'h864, 16'h0, 32'h0, PCD_RS_ERR, PCD_E_UNSUPP, 0);
  endtask : s_read

  task automatic s_pages();
    logic [7:0] codes [8] = '{PCD_PG_0, PCD_PG_2000, PCD_PG_6000, PCD_PG_8000, PCD_PG_10000,
                              PCD_PG_20000, PCD_PG_30000, PCD_PG_60000};
    int offs [8] = '{0, 2000, 6000, 8000, 10000, 20000, 30000, 60000};
    for (int i = 0; i < 8; i++) begin
      xfer(4'h1, 12'd9, {8'h00, codes[i]}, 32'h0, PCD_RS_ERR, PCD_E_NOPARAM, 0);
      chk("lookup_num", offs[i] + 9, {16'h0, seen_num});
    end
    xfer(4'h1, 12'd9, 16'h0081, 32'h0, PCD_RS_ERR, PCD_E_NOPARAM, 0);
  endtask : s_pages

  task automatic s_write();
    xfer(4'h2, 12'd100, 16'h0, 32'd500, PCD_RS_WORD, 32'd500, 2);
    xfer(4'h7, 12'd100, 16'h0, 32'd500, PCD_RS_FWORD, 32'd500, 2);
    xfer(4'h8, 12'd1841, {8'h01, PCD_PG_6000}, 32'h02D2_FC02, PCD_RS_FDWORD, 32'h02D2_FC02, 2);
    xfer(4'h2, 12'd100, 16'h0, 32'd2000, PCD_RS_ERR, PCD_E_LIMIT, 0);
    xfer(4'h2, 12'd100, 16'h0, 32'd5, PCD_RS_ERR, PCD_E_BELOW, 0);
    xfer(4'h2, 12'd100, 16'h0, 32'd950, PCD_RS_ERR, PCD_E_ABOVE, 0);
    xfer(4'h3, 12'd100, 16'h0, 32'd500, PCD_RS_ERR, PCD_E_DTYPE, 0);
    xfer(4'h2, 12'd5, {8'h00, PCD_PG_2000}, 32'd1, PCD_RS_ERR, PCD_E_RDONLY, 0);
    master_control <= 1'b0;
    xfer(4'h2, 12'd100, 16'h0, 32'd500, PCD_RS_NOAUTH, PCD_E_NOMASTER, 0);
    master_control <= 1'b1;
    protect_active <= 1'b1;
    xfer(4'h1, 12'd100, 16'h0, 32'h0, PCD_RS_ERR, PCD_E_PROTECT, 0);
    protect_active <= 1'b0;
  endtask : s_write

  task automatic s_knobs();
    logic [7:0] errs [9] = '{PCD_E_DEACT, PCD_E_OPSTATE, PCD_E_CLOOP, PCD_E_NOCODE, PCD_E_KEYWORD,
                             PCD_E_ILLVAL, PCD_E_INADM, PCD_E_COMMISS, PCD_E_RESETONLY};
    for (int i = 0; i < 9; i++) begin
      knob <= 4'(i + 1);
      xfer(4'h2, 12'd100, 16'h0, 32'd500, PCD_RS_ERR, errs[i], 0);
    end
    write_authorised <= 1'b1;
    xfer(4'h2, 12'd100, 16'h0, 32'd500, PCD_RS_WORD, 32'd500, 2);
    knob <= 4'h8;
    commissioning_state_param <= PCD_COMMISSION_STATE;
    xfer(4'h2, 12'd100, 16'h0, 32'd500, PCD_RS_WORD, 32'd500, 2);
    knob <= 4'h0;
  endtask : s_knobs

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    #1;
    chk("reset_out", 32'h0, {rsp_valid, wr_en, lookup_valid, rsp_chan[28:0]});
    @(posedge clock);
    rst_n <= 1'b1;
    s_read();
    s_pages();
    s_write();
    s_knobs();
    wrap_up();
  end
endmodule : tb_top
